// file: design/ref_clock_in_pkg.sv
// Constants and types shared by the reference clock select block.
package ref_clock_in_pkg;
  // Clock and reset pin timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_MIN_NS = 1000;
  localparam int RESET_MIN_CYCLES = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_COUNT_WIDTH = $clog2(RESET_MIN_CYCLES + 1);
  // Serial bits per parallel receive word, and half of that for the clock toggle.
  localparam int WORD_BITS = 4;
  localparam int WORD_HALF_TICKS = WORD_BITS / 2;
  // Register byte offsets.
  localparam logic [7:0] CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  // Control register fields.
  localparam int CTRL_FORCE_LTR_BIT = 0;
  localparam int CTRL_CAL_REQ_BIT = 1;
  localparam logic CTRL_FORCE_LTR_RESET = 1'b0;
  // Status register field positions.
  localparam int STAT_CMU_SRC_LSB = 0;
  localparam int STAT_CDR_SRC_LSB = 2;
  localparam int STAT_RATIO_LSB = 4;
  localparam int STAT_LTR_BIT = 10;
  localparam int STAT_PHASE_LSB = 11;
  localparam int STAT_PINS_LSB = 13;
  localparam int STAT_FIFO_RST_BIT = 18;
  // Mode pin positions inside the synchronized pin vector.
  localparam int PIN_COUNT = 5;
  localparam int PIN_LOOP_TIMING = 0;
  localparam int PIN_LOCK_TO_REF = 1;
  localparam int PIN_REF_RATE = 2;
  localparam int PIN_REF_SOURCE = 3;
  localparam int PIN_RESET = 4;
  localparam logic [PIN_COUNT-1:0] PIN_DEFAULT = 5'h1f;
  // Reference source codes.
  localparam logic [1:0] SRC_TX_WORD = 2'h0;
  localparam logic [1:0] SRC_REF_CLOCK = 2'h1;
  localparam logic [1:0] SRC_RECOVERED = 2'h2;
  // Multiplier ratios from reference to serial line rate.
  localparam logic [5:0] RATIO_TX_WORD = 6'h04;
  localparam logic [5:0] RATIO_REF_16 = 6'h10;
  localparam logic [5:0] RATIO_REF_32 = 6'h20;
  localparam logic [5:0] RATIO_LOOP = 6'h10;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Device life phases.
  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_CAL = 2'b01,
    ST_RUN = 2'b10
  } phase_type;
endpackage

// file: design/pin_sync.sv
// Three-stage pin synchronizer that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module pin_sync
  import ref_clock_in_pkg::*;
#(
  parameter int WIDTH = PIN_COUNT,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [WIDTH-1:0] PIN,
  output logic [WIDTH-1:0] SYNCED
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } sync_type;

  sync_type state;
  sync_type next_state;

  // The first stage feeds only the second; filtering looks at stages two and three.
  always_comb begin
    next_state = state;
    next_state.s1 = PIN;
    next_state.s2 = state.s1;
    next_state.s3 = state.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (state.s2[i] == state.s3[i]) begin
        next_state.q[i] = state.s3[i];
      end
    end
  end

  // Reset to the pulled-up level so that an idle pin reads high from the start.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state <= {INIT, INIT, INIT, INIT};
    end else begin
      state <= next_state;
    end
  end

  assign SYNCED = state.q;
endmodule // pin_sync

// file: design/ref_clock_in_select.sv
// Reference clock selection, reset sequencing and receive word clock with AXI4-Lite registers.
`timescale 1ns/1ps
module ref_clock_in_select
  import ref_clock_in_pkg::*;
#(
  parameter int ADDR_WIDTH = 8
) (
  // Clock and asynchronous system reset.
  input wire logic CLK,
  input wire logic RESET,

  // Mode pins and their pad-driven flags.
  input wire logic LOOP_TIMING_SELECT_N,
  input wire logic LOCK_TO_REF_N,
  input wire logic REF_RATE_SELECT,
  input wire logic REF_SOURCE_SELECT,
  input wire logic DEVICE_RESET_N,
  input wire logic [PIN_COUNT-1:0] PIN_DRIVEN,

  // Bit ticks and the calibration answer from the analog side.
  input wire logic RX_BIT_TICK,
  input wire logic REF_BIT_TICK,
  input wire logic CMU_CAL_DONE,

  // Selection and sequencing outputs.
  output logic [1:0] CMU_REF_SOURCE,
  output logic [1:0] CDR_REF_SOURCE,
  output logic [5:0] CMU_MULT_RATIO,
  output logic CDR_LOCK_TO_REF,
  output logic FIFO_POINTER_RESET,
  output logic CONTROL_INIT,
  output logic CMU_CAL_START,
  output logic CMU_CAL_BUSY,
  output logic RX_WORD_CLOCK_OUT,

  // Register bus.
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [ADDR_WIDTH-1:0] AWADDR,
  input wire logic WVALID,
  output logic WREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  output logic BVALID,
  input wire logic BREADY,
  output logic [1:0] BRESP,
  input wire logic ARVALID,
  output logic ARREADY,
  input wire logic [ADDR_WIDTH-1:0] ARADDR,
  output logic RVALID,
  input wire logic RREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP
);
  // Complete state of the block, registered in a single process.
  typedef struct packed {
    // Device phase and reset pin low counter.
    phase_type phase;
    logic [RESET_COUNT_WIDTH-1:0] low_count;

    // Registered selection seen by the analog paths.
    logic [1:0] cmu_source;
    logic [1:0] cdr_source;
    logic [5:0] ratio;
    logic lock_to_ref;
    logic fifo_reset;
    logic control_init;
    logic cal_start;
    logic cal_busy;

    // Receive word clock divider.
    logic tick_count;
    logic word_clock;

    // Software control bits.
    logic force_ltr;
    logic cal_request;

    // Write channel holding state.
    logic aw_full;
    logic [ADDR_WIDTH-1:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;

    // Read channel answer.
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_type;

  state_type state;
  state_type next_state;
  logic [PIN_COUNT-1:0] pin_raw;
  logic [PIN_COUNT-1:0] pin;

  // Combinational helpers.
  logic [1:0] ref_choice;
  logic word_tick;
  logic write_fire;

  // Register read views.
  logic [31:0] status_word;
  logic [31:0] control_word;

  // A pad that nobody drives reads as its pull-up level before synchronizing.
  assign pin_raw[PIN_LOOP_TIMING] = LOOP_TIMING_SELECT_N | ~PIN_DRIVEN[PIN_LOOP_TIMING];
  assign pin_raw[PIN_LOCK_TO_REF] = LOCK_TO_REF_N | ~PIN_DRIVEN[PIN_LOCK_TO_REF];
  assign pin_raw[PIN_REF_RATE] = REF_RATE_SELECT | ~PIN_DRIVEN[PIN_REF_RATE];
  assign pin_raw[PIN_REF_SOURCE] = REF_SOURCE_SELECT | ~PIN_DRIVEN[PIN_REF_SOURCE];
  assign pin_raw[PIN_RESET] = DEVICE_RESET_N | ~PIN_DRIVEN[PIN_RESET];

  // Every mode pin is synchronized, so a switched reference path never sees a runt select.
  pin_sync #(
    .WIDTH(PIN_COUNT),
    .INIT(PIN_DEFAULT)
  ) u_pin_sync (
    .CLK(CLK),
    .RESET(RESET),
    .PIN(pin_raw),
    .SYNCED(pin)
  );

  // Reference shared by the multiplier and clock recovery, before loop timing.
  always_comb begin
    if (pin[PIN_REF_SOURCE]) begin
      ref_choice = SRC_REF_CLOCK;
    end else begin
      ref_choice = SRC_TX_WORD;
    end
  end

  // Word clock source: the reference keeps the clock steady when no data arrives.
  assign word_tick = state.lock_to_ref ? REF_BIT_TICK : RX_BIT_TICK;

  // A write goes ahead only once both its address and its data are held.
  assign write_fire = state.aw_full && state.w_full && !state.bvalid;

  // Control read-back; the calibration request bit always reads zero.
  always_comb begin
    control_word = 32'h0;
    control_word[CTRL_FORCE_LTR_BIT] = state.force_ltr;
  end

  // Status word collects the live selection and the device phase.
  always_comb begin
    status_word = 32'h0;
    status_word[STAT_CMU_SRC_LSB +: 2] = state.cmu_source;
    status_word[STAT_CDR_SRC_LSB +: 2] = state.cdr_source;
    status_word[STAT_RATIO_LSB +: 6] = state.ratio;
    status_word[STAT_LTR_BIT] = state.lock_to_ref;
    status_word[STAT_PHASE_LSB +: 2] = state.phase;
    status_word[STAT_PINS_LSB +: PIN_COUNT] = pin;
    status_word[STAT_FIFO_RST_BIT] = state.fifo_reset;
  end

  // Next-state logic for the device phase, mode selection, word clock and bus slave.
  always_comb begin
    next_state = state;
    next_state.cal_start = 1'b0;
    next_state.cal_request = 1'b0;

    // The multiplier follows the shared reference unless loop timing takes over.
    next_state.cdr_source = ref_choice;
    if (!pin[PIN_LOOP_TIMING]) begin
      next_state.cmu_source = SRC_RECOVERED;
      next_state.ratio = RATIO_LOOP;
    end else begin
      next_state.cmu_source = ref_choice;
      if (!pin[PIN_REF_SOURCE]) begin
        next_state.ratio = RATIO_TX_WORD;
      end else if (pin[PIN_REF_RATE]) begin
        next_state.ratio = RATIO_REF_16;
      end else begin
        next_state.ratio = RATIO_REF_32;
      end
    end
    // Software may force reference lock in addition to the pin.
    next_state.lock_to_ref = !pin[PIN_LOCK_TO_REF] || state.force_ltr;

    // Count how long the reset pin has been low; short dips are not a reset.
    if (!pin[PIN_RESET]) begin
      if (state.low_count != RESET_COUNT_WIDTH'(RESET_MIN_CYCLES)) begin
        next_state.low_count = state.low_count + 1'b1;
      end
    end else begin
      next_state.low_count = '0;
    end

    // Device phase sequence; a long enough low on the pin wins over everything.
    unique case (state.phase)
      ST_RESET: begin
        if (pin[PIN_RESET]) begin
          next_state.phase = ST_CAL;
          next_state.cal_start = 1'b1;
        end
      end
      // Calibration ends when the multiplier reports done.
      ST_CAL: begin
        if (CMU_CAL_DONE) begin
          next_state.phase = ST_RUN;
        end
      end
      // A software request restarts calibration from run only.
      ST_RUN: begin
        if (state.cal_request) begin
          next_state.phase = ST_CAL;
          next_state.cal_start = 1'b1;
        end
      end
      default: begin
        next_state.phase = ST_RESET;
      end
    endcase

    // A full microsecond low forces the reset phase from any other phase.
    if (!pin[PIN_RESET] && state.low_count == RESET_COUNT_WIDTH'(RESET_MIN_CYCLES - 1)) begin
      next_state.phase = ST_RESET;
      next_state.cal_start = 1'b0;
    end

    // Phase outputs follow the next phase so that they switch together with it.
    next_state.fifo_reset = next_state.phase == ST_RESET;
    next_state.control_init = next_state.phase == ST_RESET;
    next_state.cal_busy = next_state.phase == ST_CAL;

    // Word clock toggles every half word, giving one period per four bit ticks.
    if (next_state.phase == ST_RESET) begin
      next_state.tick_count = 1'b0;
      next_state.word_clock = 1'b0;
    end else if (word_tick) begin
      if (state.tick_count == 1'(WORD_HALF_TICKS - 1)) begin
        next_state.tick_count = 1'b0;
        next_state.word_clock = ~state.word_clock;
      end else begin
        next_state.tick_count = state.tick_count + 1'b1;
      end
    end

    // Write address and data are taken independently and in either order.
    if (AWVALID && AWREADY) begin
      next_state.aw_full = 1'b1;
      next_state.aw_addr = AWADDR;
    end
    if (WVALID && WREADY) begin
      next_state.w_full = 1'b1;
      next_state.w_data = WDATA;
      next_state.w_strb = WSTRB;
    end
    if (write_fire) begin
      next_state.aw_full = 1'b0;
      next_state.w_full = 1'b0;
      next_state.bvalid = 1'b1;
      if (state.aw_addr[ADDR_WIDTH-1:2] == CONTROL_OFFSET[ADDR_WIDTH-1:2]) begin
        next_state.bresp = RESP_OKAY;
        if (state.w_strb[0]) begin
          next_state.force_ltr = state.w_data[CTRL_FORCE_LTR_BIT];
          next_state.cal_request = state.w_data[CTRL_CAL_REQ_BIT];
        end
      end else if (state.aw_addr[ADDR_WIDTH-1:2] == STATUS_OFFSET[ADDR_WIDTH-1:2]) begin
        next_state.bresp = RESP_OKAY;
      end else begin
        // Unmapped writes change nothing and report an error.
        next_state.bresp = RESP_SLVERR;
      end
    end else if (state.bvalid && BREADY) begin
      next_state.bvalid = 1'b0;
    end

    // Reads answer one cycle after the address is taken.
    if (ARVALID && ARREADY) begin
      next_state.rvalid = 1'b1;
      if (ARADDR[ADDR_WIDTH-1:2] == CONTROL_OFFSET[ADDR_WIDTH-1:2]) begin
        next_state.rdata = control_word;
        next_state.rresp = RESP_OKAY;
      end else if (ARADDR[ADDR_WIDTH-1:2] == STATUS_OFFSET[ADDR_WIDTH-1:2]) begin
        next_state.rdata = status_word;
        next_state.rresp = RESP_OKAY;
      end else begin
        // Unmapped reads return zero with an error.
        next_state.rdata = 32'h0;
        next_state.rresp = RESP_SLVERR;
      end
    end else if (state.rvalid && RREADY) begin
      next_state.rvalid = 1'b0;
    end
  end

  // Only constants enter under reset; the device starts in its reset phase.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state <= '0;
      state.phase <= ST_RESET;
      state.cmu_source <= SRC_REF_CLOCK;
      state.cdr_source <= SRC_REF_CLOCK;
      state.ratio <= RATIO_REF_16;
      state.fifo_reset <= 1'b1;
      state.control_init <= 1'b1;
      state.force_ltr <= CTRL_FORCE_LTR_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Handshake readies hold back a second request until the answer is gone.
  assign AWREADY = !state.aw_full && !state.bvalid;
  assign WREADY = !state.w_full && !state.bvalid;
  assign ARREADY = !state.rvalid;

  // Everything else leaves straight from the state flops.
  assign BVALID = state.bvalid;
  assign BRESP = state.bresp;
  assign RVALID = state.rvalid;
  assign RDATA = state.rdata;
  assign RRESP = state.rresp;

  // Selection outputs are registered, so the analog paths never see a glitch.
  assign CMU_REF_SOURCE = state.cmu_source;
  assign CDR_REF_SOURCE = state.cdr_source;
  assign CMU_MULT_RATIO = state.ratio;
  assign CDR_LOCK_TO_REF = state.lock_to_ref;

  // Sequencing and word clock outputs.
  assign FIFO_POINTER_RESET = state.fifo_reset;
  assign CONTROL_INIT = state.control_init;
  assign CMU_CAL_START = state.cal_start;
  assign CMU_CAL_BUSY = state.cal_busy;
  assign RX_WORD_CLOCK_OUT = state.word_clock;
endmodule // ref_clock_in_select

// file: dv/ref_clock_in_select_assertions.sv
// Port-level checks for the reference clock select block.
`timescale 1ns/1ps
module ref_clock_in_select_assertions
  import ref_clock_in_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic LOOP_TIMING_SELECT_N,
  input wire logic LOCK_TO_REF_N,
  input wire logic REF_RATE_SELECT,
  input wire logic REF_SOURCE_SELECT,
  input wire logic [PIN_COUNT-1:0] PIN_DRIVEN,
  input wire logic RX_BIT_TICK,
  input wire logic REF_BIT_TICK,
  input wire logic [1:0] CMU_REF_SOURCE,
  input wire logic [1:0] CDR_REF_SOURCE,
  input wire logic [5:0] CMU_MULT_RATIO,
  input wire logic CDR_LOCK_TO_REF,
  input wire logic FIFO_POINTER_RESET,
  input wire logic CONTROL_INIT,
  input wire logic CMU_CAL_START,
  input wire logic CMU_CAL_BUSY,
  input wire logic RX_WORD_CLOCK_OUT
);
  // Mode checks wait for eight steady cycles, which covers the synchronizer latency.
  default clocking main_clk @(posedge CLK);
  endclocking
  default disable iff (RESET);

  cal_pulse_a: assert property ($rose(CMU_CAL_BUSY) |-> CMU_CAL_START ##1 !CMU_CAL_START)
    else $error("calibration start is not a single pulse");
  release_cal_a: assert property ($fell(FIFO_POINTER_RESET) |-> CMU_CAL_START && CMU_CAL_BUSY)
    else $error("leaving reset did not start calibration");
  reset_init_a: assert property (FIFO_POINTER_RESET |-> CONTROL_INIT && !RX_WORD_CLOCK_OUT)
    else $error("reset phase outputs disagree");
  tx_word_a: assert property ((!REF_SOURCE_SELECT && PIN_DRIVEN[3] && LOOP_TIMING_SELECT_N)[*8]
    |-> CMU_REF_SOURCE == SRC_TX_WORD && CDR_REF_SOURCE == SRC_TX_WORD
    && CMU_MULT_RATIO == RATIO_TX_WORD) else $error("word clock reference not chosen");
  ref_clock_a: assert property ((REF_SOURCE_SELECT && LOOP_TIMING_SELECT_N)[*8]
    |-> CMU_REF_SOURCE == SRC_REF_CLOCK && CDR_REF_SOURCE == SRC_REF_CLOCK)
    else $error("reference clock input not chosen");
  rate_low_a: assert property ((REF_SOURCE_SELECT && LOOP_TIMING_SELECT_N && !REF_RATE_SELECT
    && PIN_DRIVEN[2])[*8] |-> CMU_MULT_RATIO == RATIO_REF_32) else $error("ratio not 32");
  loop_time_a: assert property ((!LOOP_TIMING_SELECT_N && PIN_DRIVEN[0])[*8]
    |-> CMU_REF_SOURCE == SRC_RECOVERED && CMU_MULT_RATIO == RATIO_LOOP)
    else $error("loop timing not applied");
  lock_ref_a: assert property ((!LOCK_TO_REF_N && PIN_DRIVEN[1])[*8] |-> CDR_LOCK_TO_REF)
    else $error("receiver not locked to reference");
  word_hold_a: assert property ((!RX_BIT_TICK && !REF_BIT_TICK) ##1 !FIFO_POINTER_RESET
    |-> $stable(RX_WORD_CLOCK_OUT)) else $error("word clock moved without a tick");
endmodule // ref_clock_in_select_assertions

// Attach the checker to every instance of the block.
bind ref_clock_in_select ref_clock_in_select_assertions checker_inst (.*);

// file: dv/board_model.sv
// Board-side model: bit ticks of both clock paths and the calibration answer.
`timescale 1ns/1ps
module board_model
  import ref_clock_in_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET,
  input wire logic CAL_BUSY,
  input wire logic SLOW,
  output logic RX_TICK,
  output logic REF_TICK,
  output logic CAL_DONE
);
  logic [1:0] ref_count;
  logic [5:0] wait_count;

  // Recovered ticks come every second cycle, reference ticks every third.
  // The reference never stops, so a selected reference is always valid.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      RX_TICK <= 1'b0;
      REF_TICK <= 1'b0;
      ref_count <= 2'h0;
    end else begin
      RX_TICK <= ~RX_TICK;
      ref_count <= (ref_count == 2'h2) ? 2'h0 : ref_count + 2'h1;
      REF_TICK <= (ref_count == 2'h2);
    end
  end

  // Calibration finishes a few cycles after busy, or much later when slow.
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      wait_count <= 6'h00;
      CAL_DONE <= 1'b0;
    end else begin
      wait_count <= CAL_BUSY ? wait_count + 6'h01 : 6'h00;
      CAL_DONE <= CAL_BUSY && (wait_count == (SLOW ? 6'h28 : 6'h03));
    end
  end
endmodule // board_model

// file: dv/tb_ref_clock_in_select.sv
// Self-checking bench for the reference clock select block.
`timescale 1ns/1ps
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("unexpected %s expected %h seen %h", what, exp, got); end end
module tb_ref_clock_in_select
  import ref_clock_in_pkg::*;
;
  logic CLK, RESET, LOOP_TIMING_SELECT_N, LOCK_TO_REF_N, REF_RATE_SELECT, REF_SOURCE_SELECT;
  logic DEVICE_RESET_N, RX_BIT_TICK, REF_BIT_TICK, CMU_CAL_DONE, slow;
  logic [4:0] PIN_DRIVEN;
  logic [1:0] CMU_REF_SOURCE, CDR_REF_SOURCE, BRESP, RRESP, resp;
  logic [5:0] CMU_MULT_RATIO;
  logic CDR_LOCK_TO_REF, FIFO_POINTER_RESET, CONTROL_INIT, CMU_CAL_START, CMU_CAL_BUSY;
  logic RX_WORD_CLOCK_OUT, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic ARVALID, ARREADY, RVALID, RREADY;
  logic [7:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rd;
  logic [3:0] WSTRB;
  int n_mismatch = 0;
  int check_count = 0;

  ref_clock_in_select DUT (.*);
  board_model partner (.CLK(CLK), .RESET(RESET), .CAL_BUSY(CMU_CAL_BUSY), .SLOW(slow),
    .RX_TICK(RX_BIT_TICK), .REF_TICK(REF_BIT_TICK), .CAL_DONE(CMU_CAL_DONE));

  // Free-running 100 MHz clock.
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  task print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task timed_out;
    n_mismatch++;
    $display("unexpected wait expected %h seen %h", 1'b0, 1'b1);
    print_verdict();
  endtask

  // Address and data are offered together; each is dropped once taken.
  task axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    AWVALID <= 1'b1;
    AWADDR <= a;
    WVALID <= 1'b1;
    WDATA <= d;
    BREADY <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge CLK);
      if (BVALID === 1'b1 && !aw && !w) break;
      if (aw && AWREADY === 1'b1) begin
        AWVALID <= 1'b0;
        aw = 1'b0;
      end
      if (w && WREADY === 1'b1) begin
        WVALID <= 1'b0;
        w = 1'b0;
      end
    end
    r = BRESP;
    BREADY <= 1'b0;
    if (i == 50) timed_out();
  endtask

  task axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    logic ar;
    ar = 1'b1;
    ARVALID <= 1'b1;
    ARADDR <= a;
    RREADY <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge CLK);
      if (RVALID === 1'b1 && !ar) break;
      if (ar && ARREADY === 1'b1) begin
        ARVALID <= 1'b0;
        ar = 1'b0;
      end
    end
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
    if (i == 50) timed_out();
  endtask

  // Waits for a calibration to start and to end; the partner answers it.
  task wait_cal;
    int i;
    for (i = 0; i < 100 && CMU_CAL_BUSY !== 1'b1; i++) @(posedge CLK);
    if (i == 100) timed_out();
    for (i = 0; i < 200 && CMU_CAL_BUSY !== 1'b0; i++) @(posedge CLK);
    if (i == 200) timed_out();
    `CHK("fifo reset in run", 1'b0, FIFO_POINTER_RESET)
  endtask

  // Pins are {loop, lock, rate, source}; the old source must survive the first edge.
  task check_mode(input logic [4:0] drv, input logic [3:0] pins, input logic [1:0] ecmu,
    input logic [1:0] ecdr, input logic [5:0] erat, input logic eltr);
    logic [1:0] old;
    old = CMU_REF_SOURCE;
    PIN_DRIVEN <= drv;
    {LOOP_TIMING_SELECT_N, LOCK_TO_REF_N, REF_RATE_SELECT, REF_SOURCE_SELECT} <= pins;
    @(posedge CLK);
    #1 `CHK("source before sync", old, CMU_REF_SOURCE)
    repeat (8) @(posedge CLK);
    #1 `CHK("multiplier source", ecmu, CMU_REF_SOURCE)
    `CHK("recovery source", ecdr, CDR_REF_SOURCE)
    `CHK("ratio", erat, CMU_MULT_RATIO)
    `CHK("lock to reference", eltr, CDR_LOCK_TO_REF)
    @(posedge CLK);
  endtask

  task test_modes;
    check_mode(5'h1f, 4'b1110, SRC_TX_WORD, SRC_TX_WORD, RATIO_TX_WORD, 1'b0);
    check_mode(5'h1f, 4'b1100, SRC_TX_WORD, SRC_TX_WORD, RATIO_TX_WORD, 1'b0);
    check_mode(5'h1f, 4'b1111, SRC_REF_CLOCK, SRC_REF_CLOCK, RATIO_REF_16, 1'b0);
    check_mode(5'h1f, 4'b1101, SRC_REF_CLOCK, SRC_REF_CLOCK, RATIO_REF_32, 1'b0);
    check_mode(5'h1f, 4'b0101, SRC_RECOVERED, SRC_REF_CLOCK, RATIO_LOOP, 1'b0);
    check_mode(5'h1f, 4'b1011, SRC_REF_CLOCK, SRC_REF_CLOCK, RATIO_REF_16, 1'b1);
    check_mode(5'h10, 4'b0000, SRC_REF_CLOCK, SRC_REF_CLOCK, RATIO_REF_16, 1'b0);
    check_mode(5'h1f, 4'b1111, SRC_REF_CLOCK, SRC_REF_CLOCK, RATIO_REF_16, 1'b0);
  endtask

  // Reset values, an unmapped place, a read-only place and a recalibration request.
  task test_registers;
    axi_read(CONTROL_OFFSET, rd, resp);
    `CHK("control reset", 32'h0, rd)
    axi_read(8'h08, rd, resp);
    `CHK("unmapped read", RESP_SLVERR, resp)
    axi_write(8'h0c, 32'h1, resp);
    `CHK("unmapped write", RESP_SLVERR, resp)
    axi_write(STATUS_OFFSET, 32'hffffffff, resp);
    `CHK("status write", RESP_OKAY, resp)
    WSTRB <= 4'h0;
    axi_write(CONTROL_OFFSET, 32'h1, resp);
    WSTRB <= 4'hf;
    axi_read(CONTROL_OFFSET, rd, resp);
    `CHK("masked write", 32'h0, rd)
    `CHK("control read", RESP_OKAY, resp)
    axi_read(STATUS_OFFSET, rd, resp);
    `CHK("status phase", 2'h2, rd[12:11])
    `CHK("status ratio", RATIO_REF_16, rd[9:4])
    slow <= 1'b1;
    axi_write(CONTROL_OFFSET, 32'h2, resp);
    `CHK("control write", RESP_OKAY, resp)
    wait_cal();
  endtask

  task count_toggles(output int n);
    logic last;
    n = 0;
    last = RX_WORD_CLOCK_OUT;
    repeat (120) begin
      @(posedge CLK);
      if (RX_WORD_CLOCK_OUT !== last) n++;
      last = RX_WORD_CLOCK_OUT;
    end
  endtask

  // Recovered ticks every 2 cycles give 30 toggles in 120; reference ticks every 3 give 20.
  task test_word_clock;
    int n;
    count_toggles(n);
    `CHK("recovered toggles", 1'b1, n >= 29 && n <= 31)
    axi_write(CONTROL_OFFSET, 32'h1, resp);
    count_toggles(n);
    `CHK("reference toggles", 1'b1, n >= 19 && n <= 21)
    `CHK("forced lock", 1'b1, CDR_LOCK_TO_REF)
    axi_write(CONTROL_OFFSET, 32'h0, resp);
  endtask

  // A floating reset pin and a short low must not reset; a long low must.
  task test_device_reset;
    PIN_DRIVEN <= 5'h0f;
    DEVICE_RESET_N <= 1'b0;
    repeat (120) @(posedge CLK);
    #1 `CHK("floating reset pin", 1'b0, FIFO_POINTER_RESET)
    @(posedge CLK);
    PIN_DRIVEN <= 5'h1f;
    DEVICE_RESET_N <= 1'b1;
    repeat (10) @(posedge CLK);
    DEVICE_RESET_N <= 1'b0;
    repeat (50) @(posedge CLK);
    DEVICE_RESET_N <= 1'b1;
    repeat (10) @(posedge CLK);
    #1 `CHK("short reset low", 1'b0, FIFO_POINTER_RESET)
    @(posedge CLK);
    DEVICE_RESET_N <= 1'b0;
    repeat (120) @(posedge CLK);
    #1 `CHK("long reset low", 1'b1, FIFO_POINTER_RESET)
    `CHK("control init", 1'b1, CONTROL_INIT)
    @(posedge CLK);
    DEVICE_RESET_N <= 1'b1;
    wait_cal();
  endtask

  // Main sequence: reset held for 21 cycles, then every scenario in turn.
  initial begin
    RESET = 1'b1;
    {LOOP_TIMING_SELECT_N, LOCK_TO_REF_N, REF_RATE_SELECT, REF_SOURCE_SELECT} = 4'hf;
    DEVICE_RESET_N = 1'b1;
    PIN_DRIVEN = 5'h1f;
    slow = 1'b0;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY} = 5'h00;
    AWADDR = 8'h00;
    ARADDR = 8'h00;
    WDATA = 32'h0;
    WSTRB = 4'hf;
    repeat (20) @(posedge CLK);
    #1 `CHK("fifo reset in reset", 1'b1, FIFO_POINTER_RESET)
    @(posedge CLK);
    RESET <= 1'b0;
    wait_cal();
    test_modes();
    test_registers();
    test_word_clock();
    test_device_reset();
    print_verdict();
  end
endmodule // tb_ref_clock_in_select
